// ### verilog/port_e_pkg.sv
// Constants, field positions and carrier types for the multiplexed port block
package port_e_pkg;
	localparam int PORT_W = 8;
	localparam int ADDR_W = 5;
	localparam int NARROW_W = 6;
	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL = 5'h00;
	localparam logic [ADDR_W-1:0] ADDR_LATCH = 5'h04;
	localparam logic [ADDR_W-1:0] ADDR_DIRECTION = 5'h08;
	localparam logic [ADDR_W-1:0] ADDR_FIRST_LATCH = 5'h0C;
	localparam logic [ADDR_W-1:0] ADDR_MEM_IF_CTRL = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_PS_CTRL = 5'h14;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h18;
	// Field positions
	localparam int PULLUP_ENABLE_BIT = 6;
	localparam int EXT_BUS_DISABLE_BIT = 7;
	localparam int PS_ENABLE_BIT = 4;
	localparam int PIN_BIT_SEVEN = 7;
	localparam int PAIR_LO_BIT = 3;
	localparam int PAIR_HI_BIT = 6;
	localparam int PS_RD_BIT = 0;
	localparam int PS_WR_BIT = 1;
	localparam int PS_CS_BIT = 2;
	// Reset values and implemented-pin masks
	localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
	localparam logic [PORT_W-1:0] DIRECTION_RST = 8'hFF;
	localparam logic [PORT_W-1:0] FIRST_LATCH_RST = 8'h00;
	localparam logic EXT_BUS_DISABLE_RST = 1'b1;
	localparam logic PS_ENABLE_RST = 1'b0;
	localparam logic [PORT_W-1:0] MASK_NARROW = 8'h3F;
	localparam logic [PORT_W-1:0] MASK_FULL = 8'hFF;
	// Package option strap codes and bus response codes
	localparam logic [1:0] PKG_SMALL = 2'h0;
	localparam logic [1:0] PKG_MID = 2'h1;
	localparam logic [1:0] PKG_LARGE = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Enhanced PWM sources, indexed by their default pin
	typedef struct packed {
		logic [PORT_W-1:0] level;
		logic [PORT_W-1:0] enable;
		logic [PORT_W-1:0] tristate;
	} pwm_in_t;

	// High address/data byte of the external memory interface
	typedef struct packed {
		logic [PORT_W-1:0] data;
		logic [PORT_W-1:0] oe;
	} ext_bus_t;

	// Parallel slave control inputs
	typedef struct packed {
		logic rd;
		logic wr;
		logic cs;
	} ps_ctrl_t;

	// Register access request from the bus slave
	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] waddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              rd;
		logic [ADDR_W-1:0] raddr;
	} reg_req_t;
endpackage

// ### verilog/axil_reg_slave.sv
// AXI4-Lite slave front end turning bus transfers into register strobes
module axil_reg_slave
	import port_e_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// Write channels
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// Read channels
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Register side
	output reg_req_t               req,
	input  wire logic              wr_ok,
	input  wire logic              rd_ok,
	input  wire logic [31:0]       rd_data
);
	logic              aw_have_reg;
	logic              w_have_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              aw_fire;
	logic              w_fire;
	logic              do_write;
	logic              ar_fire;

	// Address and data may arrive in either order; each is held until both are in
	assign awready = !aw_have_reg && !bvalid;
	assign wready = !w_have_reg && !bvalid;
	assign arready = !rvalid;
	assign aw_fire = awvalid && awready;
	assign w_fire = wvalid && wready;
	assign ar_fire = arvalid && arready;
	assign do_write = (aw_have_reg || aw_fire) && (w_have_reg || w_fire);
	assign req.wr = do_write;
	assign req.waddr = aw_have_reg ? awaddr_reg : awaddr;
	assign req.wdata = w_have_reg ? wdata_reg : wdata;
	assign req.wstrb = w_have_reg ? wstrb_reg : wstrb;
	assign req.rd = ar_fire;
	assign req.raddr = araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn || do_write) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
		end else begin
			aw_have_reg <= aw_have_reg || aw_fire;
			w_have_reg <= w_have_reg || w_fire;
		end
		if (aw_fire) begin
			awaddr_reg <= awaddr;
		end
		if (w_fire) begin
			wdata_reg <= wdata;
			wstrb_reg <= wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp <= RESP_OKAY;
			rdata <= 32'h00000000;
		end else begin
			if (do_write) begin
				bvalid <= 1'b1;
				bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (ar_fire) begin
				rvalid <= 1'b1;
				rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
				rdata <= rd_ok ? rd_data : 32'h00000000;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule

// ### verilog/port_e_pin_mux.sv
// Eight-pin general purpose port with external bus, PWM and parallel slave muxing
// Summary of operation
// - Six pins small package, eight otherwise
// - Direction one tri-states the pin driver
// - Direction zero drives the output latch
// - Latch reads return latched value, not pins
// - Every reset leaves all pins as inputs
// - Enabled memory bus owns pins, overrides direction
// - Memory bus beats every other function; PWM2 capture input still follows bit seven
// - One shared bit enables all pull-ups
// - Output pins never get their pull-up
// - Reset turns all pull-ups off
// - PWM outputs default onto low seven bits
// - Remap bit cleared moves pairs elsewhere
// - Alternate select cleared in micro mode puts PWM2 on bit seven
// - Parallel slave enable claims bits zero-two; the code only raises ps_ctrl_valid, and the pin drivers still follow direction
// - Bits zero-two become read, write, select
// - PWM overrides latch, may tri-state on shutdown
// - Memory bus controls its own direction
// - Missing upper bits read as zero
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
module port_e_pin_mux
	import port_e_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite register bus
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// Configuration straps
	input  wire logic [1:0]        pkg_sel,
	input  wire logic              pwm_pair_remap,
	input  wire logic              pwm2_alt_pin_select,
	input  wire logic              micro_mode,
	// Peripheral sources on the same clock
	input  pwm_in_t                pwm,
	input  ext_bus_t               ext_bus,
	// Peripheral sinks
	output logic [PORT_W-1:0]      ext_bus_high_byte_in,
	output logic                   ext_bus_active,
	output ps_ctrl_t               ps_ctrl,
	output logic                   ps_ctrl_valid,
	output logic                   pwm2_capture_in,
	output logic                   pwm_pairs_on_port_h,
	// Pins
	input  wire logic [PORT_W-1:0] pin_in,
	output logic [PORT_W-1:0]      pin_out,
	output logic [PORT_W-1:0]      pin_oe,
	output logic [PORT_W-1:0]      pin_pullup
);
	reg_req_t          req;
	logic              wr_ok;
	logic              rd_ok;
	logic [31:0]       rd_data;
	logic [PORT_W-1:0] pin_meta_reg;
	logic [PORT_W-1:0] pin_sync_reg;
	logic [4:0]        strap_meta_reg;
	logic [4:0]        strap_sync_reg;
	logic [PORT_W-1:0] latch_reg;
	logic [PORT_W-1:0] latch_next;
	logic [PORT_W-1:0] dir_reg;
	logic [PORT_W-1:0] dir_next;
	logic [PORT_W-1:0] first_port_latch_reg;
	logic [PORT_W-1:0] first_port_latch_next;
	logic              ext_bus_disable_reg;
	logic              ext_bus_disable_next;
	logic              ps_enable_reg;
	logic              ps_enable_next;
	logic [PORT_W-1:0] out_next;
	logic [PORT_W-1:0] oe_next;
	logic [PORT_W-1:0] pullup_next;
	logic [PORT_W-1:0] impl_mask;
	logic [PORT_W-1:0] pwm_here;
	logic [PORT_W-1:0] pwm_on;
	logic [1:0]        pkg_q;
	logic              remap_q;
	logic              alt_sel_q;
	logic              micro_q;
	logic              pkg_is_small;
	logic              pkg_is_large;
	logic              pullup_enable;
	logic              lane0;
	logic              wr_pin_level;
	logic              wr_latch;
	logic              wr_dir;
	logic              wr_first;
	logic              wr_mem_if;
	logic              wr_ps;

	axil_reg_slave u_bus (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.req     (req),
		.wr_ok   (wr_ok),
		.rd_ok   (rd_ok),
		.rd_data (rd_data)
	);

	// Pins and straps come from outside the clock domain
	always_ff @(posedge aclk) begin
		pin_meta_reg <= pin_in;
		pin_sync_reg <= pin_meta_reg;
		strap_meta_reg <= {pkg_sel, pwm_pair_remap, pwm2_alt_pin_select, micro_mode};
		strap_sync_reg <= strap_meta_reg;
	end

	assign pkg_q = strap_sync_reg[4:3];
	assign remap_q = strap_sync_reg[2];
	assign alt_sel_q = strap_sync_reg[1];
	assign micro_q = strap_sync_reg[0];
	assign pkg_is_small = (pkg_q == PKG_SMALL);
	assign pkg_is_large = (pkg_q == PKG_LARGE);
	assign impl_mask = pkg_is_small ? MASK_NARROW : MASK_FULL;
	assign pullup_enable = first_port_latch_reg[PULLUP_ENABLE_BIT];
	assign ext_bus_active = pkg_is_large && !ext_bus_disable_reg;
	assign pwm_pairs_on_port_h = !pkg_is_small && !remap_q;

	// Register decode
	assign lane0 = req.wr && req.wstrb[0];
	assign wr_pin_level = lane0 && (req.waddr == ADDR_PIN_LEVEL);
	assign wr_latch = lane0 && (req.waddr == ADDR_LATCH);
	assign wr_dir = lane0 && (req.waddr == ADDR_DIRECTION);
	assign wr_first = lane0 && (req.waddr == ADDR_FIRST_LATCH);
	assign wr_mem_if = lane0 && (req.waddr == ADDR_MEM_IF_CTRL);
	assign wr_ps = lane0 && (req.waddr == ADDR_PS_CTRL);
	assign wr_ok = (req.waddr <= ADDR_PS_CTRL) && (req.waddr[1:0] == 2'h0);
	assign rd_ok = (req.raddr <= ADDR_STATUS) && (req.raddr[1:0] == 2'h0);

	// Both pin and latch addresses write the latch
	assign latch_next = (wr_pin_level || wr_latch) ? req.wdata[PORT_W-1:0] : latch_reg;
	assign dir_next = wr_dir ? req.wdata[PORT_W-1:0] : dir_reg;
	assign first_port_latch_next = wr_first ? req.wdata[PORT_W-1:0] : first_port_latch_reg;
	assign ext_bus_disable_next = wr_mem_if ? req.wdata[EXT_BUS_DISABLE_BIT] : ext_bus_disable_reg;
	assign ps_enable_next = wr_ps ? req.wdata[PS_ENABLE_BIT] : ps_enable_reg;

	always_comb begin
		rd_data = 32'h00000000;
		case (req.raddr)
			ADDR_PIN_LEVEL: rd_data[PORT_W-1:0] = pin_sync_reg & impl_mask;
			ADDR_LATCH: rd_data[PORT_W-1:0] = latch_reg & impl_mask;
			ADDR_DIRECTION: rd_data[PORT_W-1:0] = dir_reg & impl_mask;
			ADDR_FIRST_LATCH: rd_data[PORT_W-1:0] = first_port_latch_reg;
			ADDR_MEM_IF_CTRL: rd_data[EXT_BUS_DISABLE_BIT] = ext_bus_disable_reg;
			ADDR_PS_CTRL: rd_data[PS_ENABLE_BIT] = ps_enable_reg;
			ADDR_STATUS: rd_data[PORT_W-1:0] = pin_oe;
			default: rd_data = 32'h00000000;
		endcase
	end

	// Every reset returns the port to inputs with pull-ups off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_reg <= LATCH_RST;
			dir_reg <= DIRECTION_RST;
			first_port_latch_reg <= FIRST_LATCH_RST;
			ext_bus_disable_reg <= EXT_BUS_DISABLE_RST;
			ps_enable_reg <= PS_ENABLE_RST;
		end else begin
			latch_reg <= latch_next;
			dir_reg <= dir_next;
			first_port_latch_reg <= first_port_latch_next;
			ext_bus_disable_reg <= ext_bus_disable_next;
			ps_enable_reg <= ps_enable_next;
		end
	end

	// Per-pin function selection, highest priority first
	for (genvar i = 0; i < PORT_W; i++) begin : g_pin
		if (i == PIN_BIT_SEVEN) begin : g_seven
			assign pwm_here[i] = !pkg_is_small && micro_q && !alt_sel_q;
		end else if (i >= PAIR_LO_BIT && i <= PAIR_HI_BIT) begin : g_pair
			assign pwm_here[i] = pkg_is_small || remap_q;
		end else begin : g_fixed
			assign pwm_here[i] = 1'b1;
		end
		assign pwm_on[i] = impl_mask[i] && pwm_here[i] && pwm.enable[i];

		always_comb begin
			if (!impl_mask[i]) begin
				out_next[i] = 1'b0;
				oe_next[i] = 1'b0;
			end else if (ext_bus_active) begin
				out_next[i] = ext_bus.data[i];
				oe_next[i] = ext_bus.oe[i];
			end else if (pwm_on[i]) begin
				out_next[i] = pwm.level[i];
				oe_next[i] = !dir_reg[i] && !pwm.tristate[i];
			end else begin
				out_next[i] = latch_reg[i];
				oe_next[i] = !dir_reg[i];
			end
		end
		// Pull-up follows the input direction only; bus cycles never see it
		assign pullup_next[i] = impl_mask[i] && !ext_bus_active && pullup_enable && dir_reg[i];
	end

	// Driven pins are registered so the pads see glitch-free levels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= '0;
			pin_oe <= '0;
			pin_pullup <= '0;
		end else begin
			pin_out <= out_next;
			pin_oe <= oe_next;
			pin_pullup <= pullup_next;
		end
	end

	// Parallel slave control is only meaningful on the large package without the bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ps_ctrl <= '0;
			ps_ctrl_valid <= 1'b0;
			ext_bus_high_byte_in <= '0;
			pwm2_capture_in <= 1'b0;
		end else begin
			ps_ctrl.rd <= pin_sync_reg[PS_RD_BIT];
			ps_ctrl.wr <= pin_sync_reg[PS_WR_BIT];
			ps_ctrl.cs <= pin_sync_reg[PS_CS_BIT];
			ps_ctrl_valid <= ps_enable_reg && pkg_is_large && !ext_bus_active;
			ext_bus_high_byte_in <= pin_sync_reg;
			pwm2_capture_in <= pwm_here[PIN_BIT_SEVEN] && pin_sync_reg[PIN_BIT_SEVEN];
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_read_of(logic [ADDR_W-1:0] a);
		arvalid && arready && (araddr == a);
	endsequence

	a_reset_inputs: assert property ($rose(aresetn) |-> pin_oe == 8'h00 && pin_pullup == 8'h00)
		else $error("pins not inputs after reset");
	a_dir_tristate: assert property ($past(!ext_bus_active) |-> (pin_oe & $past(dir_reg)) == 8'h00)
		else $error("input pin is driven");
	a_latch_drive: assert property ($past(!ext_bus_active && pwm_on == 8'h00)
		|-> pin_oe == $past(~dir_reg & impl_mask) && (pin_out & pin_oe) == ($past(latch_reg) & pin_oe))
		else $error("output pin does not carry latch");
	a_bus_owns: assert property ($past(ext_bus_active)
		|-> pin_oe == $past(ext_bus.oe) && pin_out == $past(ext_bus.data) && !ps_ctrl_valid)
		else $error("memory bus lost its pins");
	a_pullup_gate: assert property ((pin_pullup & ~$past(dir_reg)) == 8'h00
		&& ($past(!pullup_enable) -> pin_pullup == 8'h00))
		else $error("pull-up on output or disabled");
	a_pwm_override: assert property ($past(!ext_bus_active)
		|-> ((pin_out ^ $past(pwm.level)) & $past(pwm_on) & pin_oe) == 8'h00)
		else $error("pwm did not override latch");
	a_latch_read: assert property (s_read_of(ADDR_LATCH) |=> rdata[PORT_W-1:0] == $past(latch_reg & impl_mask))
		else $error("latch read not latched value");
	a_pin_read: assert property (s_read_of(ADDR_PIN_LEVEL) |=> rdata[PORT_W-1:0] == $past(pin_sync_reg & impl_mask))
		else $error("pin read wrong");
	a_narrow_top: assert property (pkg_is_small ##1 pkg_is_small
		|-> pin_oe[7:6] == 2'h0 && pin_pullup[7:6] == 2'h0)
		else $error("missing pins active");
	a_slave_claim: assert property (ps_enable_reg && pkg_is_large && !ext_bus_active |=> ps_ctrl_valid)
		else $error("parallel slave control not claimed");
endmodule

// ### testbench/pin_model.sv
// Behavioural pads and board around the port
module pin_model
	import port_e_pkg::*;
(
	// Clock
	input  wire logic              aclk,
	// Design side
	input  wire logic [PORT_W-1:0] pin_out,
	input  wire logic [PORT_W-1:0] pin_oe,
	input  wire logic [PORT_W-1:0] pin_pullup,
	// Board side
	input  wire logic [PORT_W-1:0] ext_val,
	input  wire logic [PORT_W-1:0] ext_en,
	output logic [PORT_W-1:0]      pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// A floating pad toggles so a missing pull-up never reads as a lucky constant
	logic [PORT_W-1:0] float_reg = 8'h55;
	always @(posedge aclk) begin
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < PORT_W; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pin_pullup[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = float_reg[i];
		end
	end
endmodule

// ### testbench/tb_port_e_pin_mux.sv
// Self-checking bench for the multiplexed port
module tb_port_e_pin_mux
	import port_e_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              aclk, aresetn;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready;
	logic [31:0]       wdata, rdata, rd_seen;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, resp_seen, pkg_sel;
	logic              pwm_pair_remap, pwm2_alt_pin_select, micro_mode;
	pwm_in_t           pwm;
	ext_bus_t          ext_bus;
	ps_ctrl_t          ps_ctrl;
	logic [PORT_W-1:0] hi_byte, pin_in, pin_out, pin_oe, pin_pullup, ext_val, ext_en;
	logic              ext_bus_active, ps_ctrl_valid, pwm2_capture_in, pwm_pairs_on_port_h;
	int                fail_count = 0;
	int                samples_checked = 0;

	port_e_pin_mux u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.pkg_sel(pkg_sel), .pwm_pair_remap(pwm_pair_remap), .pwm2_alt_pin_select(pwm2_alt_pin_select),
		.micro_mode(micro_mode), .pwm(pwm), .ext_bus(ext_bus), .ext_bus_high_byte_in(hi_byte),
		.ext_bus_active(ext_bus_active), .ps_ctrl(ps_ctrl), .ps_ctrl_valid(ps_ctrl_valid),
		.pwm2_capture_in(pwm2_capture_in), .pwm_pairs_on_port_h(pwm_pairs_on_port_h),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));
	pin_model u_pins (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
		.ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic wrap_up;
		if (fail_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	// Channels are released one by one as each is taken; no fixed latency assumed
	// Handshakes are judged on settled values before the edge, so a ready that drops there is not missed
	task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic       aw_t;
		logic       w_t;
		logic       b_t;
		logic [1:0] r_t;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n <= 50; n++) begin
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid;
			r_t = bresp;
			@(posedge aclk);
			if (n == 50) chk("write response", 1, 0);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t || n == 50) begin
				resp_seen = r_t;
				break;
			end
		end
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [ADDR_W-1:0] a);
		logic        ar_t;
		logic        v_t;
		logic [31:0] d_t;
		logic [1:0]  r_t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n <= 50; n++) begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			v_t = rvalid;
			d_t = rdata;
			r_t = rresp;
			@(posedge aclk);
			if (n == 50) chk("read response", 1, 0);
			if (ar_t) arvalid <= 1'b0;
			if (v_t || n == 50) begin
				rd_seen = d_t;
				resp_seen = r_t;
				break;
			end
		end
		rready <= 1'b0;
	endtask
	task automatic rd_chk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		axi_rd(a);
		chk(name, exp, rd_seen);
	endtask
	// Straps and pins pass two sync stages before they show
	task automatic settle;
		repeat (4) @(posedge aclk);
		#1;
	endtask

	task automatic t_reset;
		chk("oe after reset", 8'h00, pin_oe);
		chk("pullup after reset", 8'h00, pin_pullup);
		rd_chk("direction", ADDR_DIRECTION, 32'h000000FF);
		rd_chk("latch", ADDR_LATCH, 32'h00000000);
		rd_chk("first latch", ADDR_FIRST_LATCH, 32'h00000000);
		rd_chk("mem ctrl", ADDR_MEM_IF_CTRL, 32'h00000080);
		chk("bus active", 1'b0, ext_bus_active);
	endtask
	task automatic t_dir_latch;
		axi_wr(ADDR_LATCH, 8'hA5);
		chk("write bresp", RESP_OKAY, resp_seen);
		axi_wr(ADDR_DIRECTION, 8'h0F);
		ext_val <= 8'h3C;
		ext_en <= 8'h0F;
		settle;
		chk("oe", 8'hF0, pin_oe);
		chk("out", 8'hA0, pin_out & 8'hF0);
		rd_chk("pin level", ADDR_PIN_LEVEL, 32'h000000AC);
		rd_chk("latch", ADDR_LATCH, 32'h000000A5);
		axi_wr(ADDR_PIN_LEVEL, 8'h5A);
		rd_chk("latch via pins", ADDR_LATCH, 32'h0000005A);
		rd_chk("status", ADDR_STATUS, 32'h000000F0);
	endtask
	task automatic t_pullup;
		ext_en <= 8'h00;
		axi_wr(ADDR_FIRST_LATCH, 8'h40);
		settle;
		chk("pullup", 8'h0F, pin_pullup);
		rd_chk("pulled pins", ADDR_PIN_LEVEL, 32'h0000005F);
		rd_chk("first latch", ADDR_FIRST_LATCH, 32'h00000040);
	endtask
	task automatic t_bus;
		pwm <= {8'h00, 8'hFF, 8'h00};
		ext_bus <= {8'h5A, 8'h0F};
		ext_val <= 8'h30;
		ext_en <= 8'hF0;
		axi_wr(ADDR_MEM_IF_CTRL, 8'h00);
		settle;
		chk("bus active", 1'b1, ext_bus_active);
		chk("bus oe", 8'h0F, pin_oe);
		chk("bus out", 8'h0A, pin_out & 8'h0F);
		chk("bus pullup", 8'h00, pin_pullup);
		chk("bus in", 8'h3A, hi_byte);
		axi_wr(ADDR_MEM_IF_CTRL, 8'h80);
		settle;
		chk("port back", 8'hF0, pin_oe);
	endtask
	task automatic t_pwm;
		ext_en <= 8'h00;
		pwm <= {8'hD5, 8'hFF, 8'h01};
		axi_wr(ADDR_DIRECTION, 8'h00);
		settle;
		chk("pwm oe", 8'hFE, pin_oe);
		chk("pwm out", 8'h54, pin_out & 8'hFE);
		pwm_pair_remap <= 1'b0;
		settle;
		chk("pairs moved", 1'b1, pwm_pairs_on_port_h);
		chk("pairs out", 8'h5C, pin_out & 8'hFE);
		pwm_pair_remap <= 1'b1;
		pwm2_alt_pin_select <= 1'b0;
		micro_mode <= 1'b1;
		settle;
		chk("pin seven pwm", 8'hD4, pin_out & 8'hFE);
		ext_val <= 8'h80;
		ext_en <= 8'h80;
		axi_wr(ADDR_DIRECTION, 8'h80);
		settle;
		chk("capture in", 1'b1, pwm2_capture_in);
		pwm2_alt_pin_select <= 1'b1;
		pwm <= {8'h00, 8'h00, 8'h00};
	endtask
	task automatic t_psp;
		axi_wr(ADDR_DIRECTION, 8'h07);
		axi_wr(ADDR_PS_CTRL, 8'h10);
		ext_val <= 8'h01;
		ext_en <= 8'h07;
		settle;
		chk("ps valid", 1'b1, ps_ctrl_valid);
		chk("ps oe", 8'hF8, pin_oe);
		chk("ps ctrl", 3'b100, ps_ctrl);
		ext_val <= 8'h06;
		settle;
		chk("ps ctrl", 3'b011, ps_ctrl);
	endtask
	task automatic t_small;
		pkg_sel <= PKG_SMALL;
		axi_wr(ADDR_DIRECTION, 8'h00);
		settle;
		chk("small oe", 8'h3F, pin_oe);
		axi_wr(ADDR_DIRECTION, 8'hFF);
		settle;
		rd_chk("small direction", ADDR_DIRECTION, 32'h0000003F);
		rd_chk("small latch", ADDR_LATCH, 32'h0000001A);
		chk("small pullup", 8'h3F, pin_pullup);
		rd_chk("unmapped data", 5'h1C, 32'h00000000);
		chk("unmapped rresp", RESP_SLVERR, resp_seen);
		axi_wr(5'h1C, 8'hFF);
		chk("unmapped bresp", RESP_SLVERR, resp_seen);
		axi_wr(ADDR_DIRECTION, 8'h00);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk("oe second reset", 8'h00, pin_oe);
		chk("pullup second reset", 8'h00, pin_pullup);
	endtask

	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hF;
		pkg_sel = PKG_LARGE;
		pwm_pair_remap = 1'b1;
		pwm2_alt_pin_select = 1'b1;
		micro_mode = 1'b0;
		pwm = '0;
		ext_bus = '0;
		ext_val = 8'h00;
		ext_en = 8'h00;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		settle;
		t_reset;
		t_dir_latch;
		t_pullup;
		t_bus;
		t_pwm;
		t_psp;
		t_small;
		wrap_up;
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		#(25 * 5000);
		fail_count++;
		wrap_up;
	end
endmodule
